// ===== inc/ibss_map.vh
// Behaviour
// - Inhibit strap sampled 1 skips EEPROM register loading; 0 enables loading.
// - Inhibit strap sampled within 10 clocks after reset release, ignored later.
// - Inhibit strap never affects slave answering on the two-wire bus.
// - Offset-width strap high selects multi-byte offsets; low selects single byte.
// - Offset-width strap sampled within 10 clocks after reset, later changes ignored.
// - Slave-address straps form bits 1 and 0 of own 7-bit address.
// - Software may replace strap-derived low bits of own slave address.
// - EEPROM select asserted: slave-address straps form EEPROM address low bits.
// - EEPROM select deasserted: EEPROM address low bits are 00.
// - Software may overwrite EEPROM address low bits after reset.
`ifndef IBSS_MAP_VH
`define IBSS_MAP_VH
`define IBSS_SAMPLE_CYCLES 4'hA
`define IBSS_CNT_W 4
`define IBSS_LOW_W 2
`define IBSS_LOW_RST 2'h0
`define IBSS_EE_DEFAULT 2'h0
`define IBSS_SLV_HI_RST 5'h00
`define IBSS_EE_HI_RST 5'h00
`define IBSS_STRAP_W 5
`define IBSS_POS_INHIBIT 0
`define IBSS_POS_MULTI 1
`define IBSS_POS_SA_LO 2
`define IBSS_POS_SA_HI 3
`define IBSS_POS_SEL 4
`endif

// ===== rtl/ibss_sync2.v
`timescale 1ns/10ps
module ibss_sync2 #(
  parameter W = 5
) (
  input wire i_mclk,
  input wire i_rstn,
  input wire i_ce,
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else if (i_ce) begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end
  assign o_q = sync_ff;
endmodule

// ===== rtl/ibss_top.v
`timescale 1ns/10ps
`include "ibss_map.vh"
module ibss_top (
  input wire i_mclk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_load_inhibit,
  input wire i_multibyte_offset_select,
  input wire [1:0] i_slave_addr_low_straps,
  input wire i_eeprom_addr_select,
  input wire [4:0] i_slave_addr_high,
  input wire [4:0] i_eeprom_addr_high,
  input wire i_slave_low_wr,
  input wire [1:0] i_slave_low_wdata,
  input wire i_eeprom_low_wr,
  input wire [1:0] i_eeprom_low_wdata,
  input wire i_slave_enable,
  output wire o_straps_done,
  output wire o_boot_load_en,
  output wire o_multibyte_offset,
  output wire [6:0] o_slave_addr,
  output wire [6:0] o_eeprom_addr,
  output wire o_slave_accessible
);
  // Window states
  localparam [1:0] ST_COUNT = 2'h0;
  localparam [1:0] ST_HELD = 2'h1;

  // Strap buses and decoded fields
  wire [`IBSS_STRAP_W-1:0] strap_pins;
  wire [`IBSS_STRAP_W-1:0] strap_sync;
  wire s_inhibit;
  wire s_multi;
  wire [1:0] s_sa;
  wire s_sel;
  wire sample_now;
  wire slave_wr_ok;
  wire eeprom_wr_ok;

  // Window control
  reg [1:0] st_ff;
  reg [1:0] nxt_st;
  reg [3:0] cnt_ff;
  reg [3:0] nxt_cnt;
  reg done_ff;
  reg nxt_done;

  // Held strap fields
  reg boot_en_ff;
  reg nxt_boot_en;
  reg multi_ff;
  reg nxt_multi;
  reg [1:0] slave_low_ff;
  reg [1:0] nxt_slave_low;
  reg [1:0] ee_low_ff;
  reg [1:0] nxt_ee_low;

  // Address output registers
  reg [6:0] slave_addr_ff;
  reg [6:0] nxt_slave_addr;
  reg [6:0] eeprom_addr_ff;
  reg [6:0] nxt_eeprom_addr;

  // Boot EEPROM low bits from the straps
  function [1:0] ibss_ee_low;
    input sel;
    input [1:0] sa;
    begin
      if (sel) begin
        ibss_ee_low = sa;
      end else begin
        ibss_ee_low = `IBSS_EE_DEFAULT;
      end
    end
  endfunction

  // Software write replaces a held field
  function [1:0] ibss_wr_pick;
    input wr;
    input [1:0] wdata;
    input [1:0] cur;
    begin
      if (wr) begin
        ibss_wr_pick = wdata;
      end else begin
        ibss_wr_pick = cur;
      end
    end
  endfunction

  // Strap pins gathered into one bus
  assign strap_pins[`IBSS_POS_INHIBIT] = i_load_inhibit;
  assign strap_pins[`IBSS_POS_MULTI] = i_multibyte_offset_select;
  assign strap_pins[`IBSS_POS_SA_HI:`IBSS_POS_SA_LO] =
    i_slave_addr_low_straps;
  assign strap_pins[`IBSS_POS_SEL] = i_eeprom_addr_select;

  // Straps are pins: two flops before use
  ibss_sync2 #(
    .W(`IBSS_STRAP_W)
  ) ibss_sync2_inst (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_d(strap_pins),
    .o_q(strap_sync)
  );

  assign s_inhibit = strap_sync[`IBSS_POS_INHIBIT];
  assign s_multi = strap_sync[`IBSS_POS_MULTI];
  assign s_sa = strap_sync[`IBSS_POS_SA_HI:`IBSS_POS_SA_LO];
  assign s_sel = strap_sync[`IBSS_POS_SEL];

  // Last cycle of the window latches the straps
  assign sample_now = (st_ff == ST_COUNT) &&
    (cnt_ff == (`IBSS_SAMPLE_CYCLES - 4'h1));
  // Writes count only once the straps are held
  assign slave_wr_ok = done_ff && i_slave_low_wr;
  assign eeprom_wr_ok = done_ff && i_eeprom_low_wr;

  // Window state: counting, then held until reset
  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      ST_COUNT: begin
        if (sample_now) begin
          nxt_st = ST_HELD;
        end
      end
      ST_HELD: begin
        nxt_st = ST_HELD;
      end
      default: begin
        nxt_st = ST_COUNT;
      end
    endcase
  end

  // Counts enabled clocks after reset release
  always @* begin
    nxt_cnt = cnt_ff;
    case (st_ff)
      ST_COUNT: begin
        nxt_cnt = cnt_ff + 4'h1;
      end
      default: begin
        nxt_cnt = cnt_ff;
      end
    endcase
  end

  // Done rises once and holds until reset
  always @* begin
    nxt_done = done_ff;
    case (st_ff)
      ST_COUNT: begin
        nxt_done = sample_now;
      end
      ST_HELD: begin
        nxt_done = 1'b1;
      end
      default: begin
        nxt_done = done_ff;
      end
    endcase
  end

  // Load enable is the inverse of the inhibit strap
  always @* begin
    nxt_boot_en = boot_en_ff;
    case (st_ff)
      ST_COUNT: begin
        if (sample_now) begin
          nxt_boot_en = !s_inhibit;
        end
      end
      default: begin
        nxt_boot_en = boot_en_ff;
      end
    endcase
  end

  // Offset width taken once, later changes ignored
  always @* begin
    nxt_multi = multi_ff;
    case (st_ff)
      ST_COUNT: begin
        if (sample_now) begin
          nxt_multi = s_multi;
        end
      end
      default: begin
        nxt_multi = multi_ff;
      end
    endcase
  end

  // Own address low bits: strap, then software
  always @* begin
    nxt_slave_low = slave_low_ff;
    if (sample_now) begin
      nxt_slave_low = s_sa;
    end else begin
      nxt_slave_low = ibss_wr_pick(slave_wr_ok, i_slave_low_wdata,
        slave_low_ff);
    end
  end

  // EEPROM address low bits: strap select, then software
  always @* begin
    nxt_ee_low = ee_low_ff;
    if (sample_now) begin
      nxt_ee_low = ibss_ee_low(s_sel, s_sa);
    end else begin
      nxt_ee_low = ibss_wr_pick(eeprom_wr_ok, i_eeprom_low_wdata,
        ee_low_ff);
    end
  end

  // Full addresses registered with the new low bits
  always @* begin
    nxt_slave_addr = {i_slave_addr_high, nxt_slave_low};
    nxt_eeprom_addr = {i_eeprom_addr_high, nxt_ee_low};
  end

  // State register
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= ST_COUNT;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  // Window counter
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff <= 4'h0;
    end else if (i_ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Sampling finished flag
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      done_ff <= 1'b0;
    end else if (i_ce) begin
      done_ff <= nxt_done;
    end
  end

  // Boot load enable
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      boot_en_ff <= 1'b0;
    end else if (i_ce) begin
      boot_en_ff <= nxt_boot_en;
    end
  end

  // Offset width select
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      multi_ff <= 1'b0;
    end else if (i_ce) begin
      multi_ff <= nxt_multi;
    end
  end

  // Own address low bits
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      slave_low_ff <= `IBSS_LOW_RST;
    end else if (i_ce) begin
      slave_low_ff <= nxt_slave_low;
    end
  end

  // EEPROM address low bits
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ee_low_ff <= `IBSS_LOW_RST;
    end else if (i_ce) begin
      ee_low_ff <= nxt_ee_low;
    end
  end

  // Own address output
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      slave_addr_ff <= {`IBSS_SLV_HI_RST, `IBSS_LOW_RST};
    end else if (i_ce) begin
      slave_addr_ff <= nxt_slave_addr;
    end
  end

  // EEPROM address output
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      eeprom_addr_ff <= {`IBSS_EE_HI_RST, `IBSS_LOW_RST};
    end else if (i_ce) begin
      eeprom_addr_ff <= nxt_eeprom_addr;
    end
  end

  assign o_straps_done = done_ff;
  assign o_boot_load_en = boot_en_ff;
  assign o_multibyte_offset = multi_ff;
  assign o_slave_addr = slave_addr_ff;
  assign o_eeprom_addr = eeprom_addr_ff;
  // Inhibit strap plays no part here
  assign o_slave_accessible = done_ff && i_slave_enable;
endmodule

// ===== testbench/ibss_checker.sv
`timescale 1ns/10ps
module ibss_checker (
  input wire i_mclk, i_rstn, i_slave_enable, i_slave_low_wr,
  input wire [1:0] i_slave_low_wdata,
  input wire o_straps_done, o_boot_load_en, o_slave_accessible,
  input wire [6:0] o_slave_addr);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence win; !o_straps_done[*8] ##3 o_straps_done; endsequence
  chk_done_time: assert property ($rose(i_rstn) |-> win)
    else $error("late");
  chk_done_hold: assert property (o_straps_done |=> o_straps_done)
    else $error("fell");
  chk_load_gate: assert property (o_boot_load_en |-> o_straps_done)
    else $error("early");
  chk_load_hold: assert property (o_straps_done |=>
    $stable(o_boot_load_en)) else $error("load");
  chk_slave_acc: assert property (o_slave_accessible ==
    (o_straps_done && i_slave_enable)) else $error("acc");
  chk_slave_wr: assert property (i_slave_low_wr && o_straps_done |=>
    o_slave_addr[1:0] == $past(i_slave_low_wdata)) else $error("wr");
  chk_low_hold: assert property (o_straps_done && !i_slave_low_wr |=>
    $stable(o_slave_addr[1:0])) else $error("low");
  chk_low_reset: assert property ($rose(i_rstn) |->
    o_slave_addr[1:0] == 2'h0) else $error("rst");
endmodule
bind ibss_top ibss_checker ibss_checker_inst (.*);

// ===== testbench/ibss_strap_model.sv
`timescale 1ns/10ps
module ibss_strap_model (
  input wire [4:0] i_cfg,
  input wire i_flip,
  output wire [4:0] o_straps,
  input wire i_hard_rstn,
  input wire i_tap_src_n,
  output wire o_tap_rstn);
  assign o_straps = i_flip ? ~i_cfg : i_cfg;
  // Test reset gated by hard reset
  assign o_tap_rstn = i_hard_rstn & i_tap_src_n;
endmodule

// ===== testbench/ibss_top_tb.sv
`timescale 1ns/10ps
module ibss_top_tb;
  reg i_mclk = 1'h0, i_rstn = 1'h0, f = 1'h0, w = 1'h0;
  reg [5:0] c = 6'h00;
  reg [1:0] d = 2'h0;
  reg [17:0] q[$];
  wire [4:0] s;
  wire t;
  wire [17:0] r;
  integer mismatches = 0, comparisons = 0, k;
  always #2 i_mclk = ~i_mclk;
  ibss_strap_model ibss_strap_model_inst (.i_cfg(c[4:0]), .i_flip(f),
    .o_straps(s), .i_hard_rstn(i_rstn), .i_tap_src_n(c[0]),
    .o_tap_rstn(t));
  ibss_top ibss_top_inst (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(1'h1),
    .i_load_inhibit(s[4]), .i_multibyte_offset_select(s[3]),
    .i_eeprom_addr_select(s[2]), .i_slave_addr_low_straps(s[1:0]),
    .i_slave_addr_high(5'h15), .i_eeprom_addr_high(5'h0A),
    .i_slave_low_wr(w), .i_slave_low_wdata(d), .i_eeprom_low_wr(w),
    .i_eeprom_low_wdata(~d), .i_slave_enable(c[5]), .o_straps_done(r[17]),
    .o_boot_load_en(r[16]), .o_multibyte_offset(r[15]),
    .o_slave_accessible(r[14]), .o_slave_addr(r[13:7]),
    .o_eeprom_addr(r[6:0]));
  task push(input [1:0] a, input [1:0] b);
    q.push_back({1'h1, ~c[4], c[3], c[5], 5'h15, a, 5'h0A, b});
  endtask
  task cmp(input [17:0] x);
    comparisons = comparisons + 1;
    if (r !== x) begin
      mismatches = mismatches + 1;
      $display("mismatch %0t outputs %h", $time, r);
    end
  endtask
  task cmp_tap(input x);
    comparisons = comparisons + 1;
    if (x !== 1'h0) begin
      mismatches = mismatches + 1;
      $display("mismatch %0t test reset free in hard reset", $time);
    end
  endtask
  task results;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(negedge i_mclk)
    if (q.size() > 0) cmp(q.pop_front());
  always @(negedge i_mclk)
    if (!i_rstn) cmp_tap(t);
  initial begin
    k = $urandom(32'h36E02F79);
    for (k = 0; k < 8; k = k + 1) begin
      @(posedge i_mclk);
      i_rstn <= 1'h0;
      f <= 1'h0;
      c <= $urandom;
      repeat (12) @(posedge i_mclk);
      i_rstn <= 1'h1;
      repeat (10) @(posedge i_mclk);
      f <= 1'h1;
      push(c[1:0], c[2] ? c[1:0] : 2'h0);
      repeat (4) @(posedge i_mclk);
      push(c[1:0], c[2] ? c[1:0] : 2'h0);
      d <= $urandom;
      w <= 1'h1;
      @(posedge i_mclk);
      w <= 1'h0;
      push(d, ~d);
    end
    @(posedge i_mclk);
    results;
  end
endmodule
